// *** bench/sdrc_link_properties.sv ***
// Purpose: Concurrent checks on the command link between controller and memory.
// Assumes: One clock; the controller runs burst length one at read latency CL.
// Notes: Sees only the link signals; every access closes by auto precharge.
`timescale 1ns/1ps
`include "sdrc_defines.svh"
module sdrc_link_properties #(
  parameter int CL = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [11:0] addr,
  input wire logic [1:0] dqm,
  input wire logic dq_h_oe,
  input wire logic [1:0] dq_d_oe
);
  // Command code that the memory end decodes at each edge.
  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  // Decoded commands, only valid while the clock is let through.
  wire logic rd_c = cke && (cmd == `SDRC_CMD_RD);
  wire logic wr_c = cke && (cmd == `SDRC_CMD_WR);
  wire logic act_c = cke && (cmd == `SDRC_CMD_ACT);
  wire logic pre_c = cke && (cmd == `SDRC_CMD_PRE);

  // All checks share the one clock and its reset.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // A read drives the lanes that were unmasked at the command edge.
  property p_rd_lat; rd_c |-> ##CL (dq_d_oe == ~$past(dqm, CL)); endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read beat missing");
  // Read data only appear as the answer to a read command.
  property p_oe_cause; (|dq_d_oe) |-> $past(rd_c, CL); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("stray read beat");
  // A single beat stands one cycle and then the lanes are released.
  property p_beat; rd_c ##CL 1'b1 |=> (dq_d_oe == 2'b00); endproperty
  a_beat: assert property (p_beat) else $error("beat held too long");
  // The controller drives data exactly in its write command cycle.
  property p_wr_drive; (wr_c || dq_h_oe) |-> (wr_c && dq_h_oe); endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write drive mismatch");
  // Never both ends on the data wire at once.
  property p_no_clash; !(dq_h_oe && (|dq_d_oe)); endproperty
  a_no_clash: assert property (p_no_clash) else $error("data wire clash");
  // Every column command asks for auto precharge.
  property p_ap; (rd_c || wr_c) |-> addr[`SDRC_AP_BIT]; endproperty
  a_ap: assert property (p_ap) else $error("auto precharge bit low");
  // The controller only ever closes all banks at once.
  property p_pre_all; pre_c |-> addr[`SDRC_AP_BIT]; endproperty
  a_pre_all: assert property (p_pre_all) else $error("single bank precharge");
  // Clock gating stays high since no power mode is used.
  property p_cke; cke; endproperty
  a_cke: assert property (p_cke) else $error("clock gating dropped");
  // A row open is followed by its column command after three or four cycles.
  property p_act_rcd; act_c |=> (!(rd_c || wr_c))[*2] ##[1:2] (rd_c || wr_c); endproperty
  a_act_rcd: assert property (p_act_rcd) else $error("column command late");
endmodule

// *** bench/testbench.sv ***
// Purpose: Self-checking bench joining the controller and memory ends.
// Assumes: Burst length one, read latency two, short init, small array.
// Notes: A shadow array holds what each location should read back.
`timescale 1ns/1ps
`include "sdrc_defines.svh"
module testbench;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_req = 1'b0;
  logic i_wr = 1'b0;
  logic [1:0] i_bank = 2'h0;
  logic [11:0] i_row = 12'h000;
  logic [11:0] i_col = 12'h000;
  logic [15:0] i_wdata = 16'h0000;
  logic [1:0] i_wmask = 2'h0;
  logic o_ready;
  logic [15:0] o_rdata;
  logic o_rvalid;
  int errors = 0;
  int cmp_count = 0;
  logic [15:0] shadow [int];  // Expected word by bank, row and column.
  logic [1:0] act_ba;         // Bank of the last row open.
  logic [11:0] act_row;       // Row of the last row open.
  logic [1:0] col_ba;         // Bank of the last column command.
  logic [11:0] col_addr;      // Address of the last column command.
  logic col_we_n;             // Write strobe of the last column command.
  logic [1:0] col_dqm;        // Masks at the last column command.
  logic [15:0] col_dq;        // Data wire at the last column command.
  logic [11:0] lmr_addr;      // Op code of the last mode load.
  logic pre_all = 1'b0;       // Last precharge closed all banks.
  int col_seen = 0;
  int ref_seen = 0;

  // Clock of 5 ns period.
  always #2.5 i_clk = ~i_clk;

  sdrc_if bus_if ();
  sdrc_ctrl #(.INIT_CYC(10), .CL(3'h2)) i_sdrc_ctrl (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_wr(i_wr), .i_bank(i_bank),
    .i_row(i_row), .i_col(i_col), .i_wdata(i_wdata), .i_wmask(i_wmask),
    .o_ready(o_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .bus(bus_if));
  sdrc_mem #(.ROWS(16)) i_sdrc_mem (
    .i_clk(i_clk), .i_rstn(i_rstn), .bus(bus_if));
  sdrc_link_properties #(.CL(2)) i_sdrc_link_properties (
    .i_clk(i_clk), .i_rstn(i_rstn), .cke(bus_if.cke), .cs_n(bus_if.cs_n),
    .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .ba(bus_if.ba),
    .addr(bus_if.addr), .dqm(bus_if.dqm), .dq_h_oe(bus_if.dq_h_oe),
    .dq_d_oe(bus_if.dq_d_oe));

  // Records each command the memory registers, with its address and data.
  always @(posedge i_clk) begin
    if (bus_if.cke === 1'b1 && bus_if.cs_n === 1'b0) begin
      case ({bus_if.cs_n, bus_if.ras_n, bus_if.cas_n, bus_if.we_n})
        `SDRC_CMD_ACT: begin
          act_ba = bus_if.ba;
          act_row = bus_if.addr;
        end
        `SDRC_CMD_RD, `SDRC_CMD_WR: begin
          col_ba = bus_if.ba;
          col_addr = bus_if.addr;
          col_we_n = bus_if.we_n;
          col_dqm = bus_if.dqm;
          col_dq = bus_if.dq;
          col_seen++;
        end
        `SDRC_CMD_REF: ref_seen++;
        `SDRC_CMD_PRE: pre_all = bus_if.addr[`SDRC_AP_BIT];
        `SDRC_CMD_LMR: lmr_addr = bus_if.addr;
        default: ;
      endcase
    end
  end

  // Compares one value and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Counts a used-up wait as a mismatch and ends the run.
  task automatic give_up(input logic bad);
    if (bad) begin
      chk(16'h0000, 16'h0001);
      conclude();
    end
  endtask

  // Waits, bounded, until the controller can take a request.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_ready !== 1'b1 && n < 20000);
    give_up(o_ready !== 1'b1);
  endtask

  // One access: checks the link fields, then the read word against the shadow.
  task automatic access(input logic wr, input logic [1:0] b, input logic [11:0] r,
                        input logic [8:0] c, input logic [15:0] d, input logic [1:0] m);
    int key;
    int c0;
    int n;
    logic [15:0] old;
    key = int'({b, r[3:0], c});
    c0 = col_seen;
    i_req <= 1'b1;
    i_wr <= wr;
    i_bank <= b;
    i_row <= r;
    i_col <= {3'h0, c};
    i_wdata <= d;
    i_wmask <= m;
    // The request stands until an edge finds the controller ready, so a
    // refresh taken first cannot swallow it.
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_ready !== 1'b1 && n < 20000);
    i_req <= 1'b0;
    give_up(o_ready !== 1'b1);
    n = 0;
    while (col_seen == c0 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    give_up(col_seen == c0);
    chk({14'h0, act_ba}, {14'h0, b});
    chk({4'h0, act_row}, {4'h0, r});
    chk({14'h0, col_ba}, {14'h0, b});
    chk({7'h0, col_addr[8:0]}, {7'h0, c});
    chk({15'h0, col_we_n}, {15'h0, !wr});
    if (wr) begin
      chk(col_dq, d);
      chk({14'h0, col_dqm}, {14'h0, m});
      old = shadow.exists(key) ? shadow[key] : 16'h0000;
      shadow[key] = {m[1] ? old[15:8] : d[15:8], m[0] ? old[7:0] : d[7:0]};
    end else begin
      n = 0;
      do begin
        @(posedge i_clk);
        n++;
      end while (o_rvalid !== 1'b1 && n < 20);
      chk({15'h0, o_rvalid}, 16'h0001);
      chk(o_rdata, shadow[key]);
      if (o_rvalid !== 1'b1) begin
        conclude();
      end
    end
  endtask

  // After reset the banks are closed and the mode word is loaded.
  task automatic t_init();
    wait_ready();
    chk({15'h0, pre_all}, 16'h0001);
    chk({4'h0, lmr_addr}, {4'h0, 12'h002 << `SDRC_MR_CL_LSB});
  endtask

  // Each of the four banks holds its own word at a high column.
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      access(1'b1, 2'(b), 12'(b + 3), 9'(9'h1ff - b), 16'(16'ha5c0 + b), 2'h0);
    end
    for (int b = 0; b < 4; b++) begin
      access(1'b0, 2'(b), 12'(b + 3), 9'(9'h1ff - b), 16'h0000, 2'h0);
    end
  endtask

  // Two rows of one bank back to back need the auto precharge in between.
  task automatic t_rows();
    access(1'b1, 2'h1, 12'h000, 9'h000, 16'h1111, 2'h0);
    access(1'b1, 2'h1, 12'h00f, 9'h000, 16'h2222, 2'h0);
    access(1'b0, 2'h1, 12'h000, 9'h000, 16'h0000, 2'h0);
    access(1'b0, 2'h1, 12'h00f, 9'h000, 16'h0000, 2'h0);
  endtask

  // Byte masks keep the masked lane of an earlier word.
  task automatic t_mask();
    access(1'b1, 2'h2, 12'h005, 9'h1fd, 16'h3c3c, 2'h1);
    access(1'b0, 2'h2, 12'h005, 9'h1fd, 16'h0000, 2'h0);
    access(1'b1, 2'h2, 12'h005, 9'h1fd, 16'h5a5a, 2'h2);
    access(1'b1, 2'h2, 12'h005, 9'h1fd, 16'hffff, 2'h3);
    access(1'b0, 2'h2, 12'h005, 9'h1fd, 16'h0000, 2'h0);
  endtask

  // Idle long enough for two refresh ticks; data must survive.
  task automatic t_refresh();
    int r0;
    r0 = ref_seen;
    repeat (2 * `SDRC_TREFI_CYC + 38) @(posedge i_clk);
    chk(16'((ref_seen - r0) >= 2 && (ref_seen - r0) <= 3), 16'h0001);
    access(1'b0, 2'h3, 12'h006, 9'h1fc, 16'h0000, 2'h0);
  endtask

  // Reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_init();
    t_banks();
    t_rows();
    t_mask();
    t_refresh();
    conclude();
  end
endmodule

// *** verilog/sdrc_ctrl.sv ***
// Purpose: Minimal SDRAM controller end: init, single accesses, refresh.
// Assumes: Memory on the same clock; one request at a time.
// Notes: Every access opens a row and closes it by auto precharge.
`timescale 1ns/1ps
`include "sdrc_defines.svh"
module sdrc_ctrl
  import sdrc_pkg::*;
#(
  parameter int DW = 16,
  parameter int INIT_CYC = `SDRC_INIT_CYC,
  parameter logic [2:0] CL = 3'h2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [1:0] i_bank,
  input wire logic [11:0] i_row,
  input wire logic [11:0] i_col,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [1:0] i_wmask,
  output logic o_ready,
  output logic [DW-1:0] o_rdata,
  output logic o_rvalid,
  sdrc_if.ctrl bus
);
  sdrc_hs_t st_reg;           // Sequencer state.
  logic [15:0] cnt_reg;       // Wait counter of the current state.
  logic [15:0] ref_cnt_reg;   // Cycles to the next refresh.
  logic ref_due_reg;          // A refresh is owed.
  logic wr_reg;               // Latched request kind.
  logic [11:0] col_reg;       // Latched column.
  logic [3:0] cmd_reg;        // Command on the pins.
  logic cke_reg;              // Clock gating level.
  logic [1:0] ba_reg;         // Bank on the pins.
  logic [11:0] addr_reg;      // Address on the pins.
  logic [1:0] dqm_reg;        // Masks on the pins.
  logic [DW-1:0] dqh_reg;     // Write data on the pins.
  logic dqh_oe_reg;           // Write data drive enable.

  // Refresh interval timing and the refresh slot in idle.
  wire ref_tick = (ref_cnt_reg == 16'h0000);
  wire take_req = (st_reg == HS_IDLE) & i_req & o_ready;
  wire take_ref = (st_reg == HS_IDLE) & ~take_req & ref_due_reg;

  assign bus.cke = cke_reg;
  assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd_reg; // R23
  assign bus.ba = ba_reg;
  assign bus.addr = addr_reg;
  assign bus.dqm = dqm_reg;
  assign bus.dq_h = dqh_reg;
  assign bus.dq_h_oe = dqh_oe_reg;

  // Refresh timer; a new tick wins over the clear by a refresh.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_cnt_reg <= 16'(`SDRC_TREFI_CYC);
      ref_due_reg <= 1'b0;
    end else begin
      ref_cnt_reg <= ref_tick ? 16'(`SDRC_TREFI_CYC) : ref_cnt_reg - 16'h0001;
      ref_due_reg <= ref_tick | (ref_due_reg & ~take_ref); // R10
    end
  end

  // Read data capture whenever the memory drives a lane.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= |bus.dq_d_oe;
      if (|bus.dq_d_oe) begin
        o_rdata <= bus.dq;
      end
    end
  end

  // Command sequencer; a no-operation is sent in every cycle without another command.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= HS_INIT;
      cnt_reg <= 16'(INIT_CYC);
      cke_reg <= 1'b1; // R15
      cmd_reg <= `SDRC_CMD_NOP;
      ba_reg <= 2'h0;
      addr_reg <= 12'h000;
      dqm_reg <= 2'h0;
      dqh_reg <= '0;
      dqh_oe_reg <= 1'b0;
      wr_reg <= 1'b0;
      col_reg <= 12'h000;
      o_ready <= 1'b0;
    end else begin
      cmd_reg <= `SDRC_CMD_NOP; // R23
      dqh_oe_reg <= 1'b0;
      dqm_reg <= 2'h0;
      cnt_reg <= (cnt_reg == 16'h0000) ? cnt_reg : cnt_reg - 16'h0001;
      unique case (st_reg)
        HS_INIT: begin
          // Close every bank before the mode word is loaded.
          if (cnt_reg == 16'h0000) begin
            cmd_reg <= `SDRC_CMD_PRE;
            addr_reg <= 12'h400;
            cnt_reg <= 16'(`SDRC_TRP_CYC);
            st_reg <= HS_LMR;
          end
        end
        HS_LMR: begin
          // Mode word: single-location bursts, chosen read latency.
          if (cnt_reg == 16'h0000) begin
            cmd_reg <= `SDRC_CMD_LMR;
            addr_reg <= {5'h00, CL, 4'h0};
            cnt_reg <= 16'(`SDRC_LMR_CYC);
            st_reg <= HS_WAIT;
          end
        end
        HS_IDLE: begin
          if (take_req) begin
            // Open the row first; the column command follows.
            cmd_reg <= `SDRC_CMD_ACT; // R3
            ba_reg <= i_bank;
            addr_reg <= i_row;
            wr_reg <= i_wr;
            col_reg <= i_col;
            dqh_reg <= i_wdata;
            dqm_reg <= i_wmask;
            cnt_reg <= 16'(`SDRC_TRCD_CYC - 1);
            o_ready <= 1'b0;
            st_reg <= HS_RW;
          end else if (take_ref) begin
            cmd_reg <= `SDRC_CMD_REF; // R10
            cnt_reg <= 16'(`SDRC_TRFC_CYC);
            o_ready <= 1'b0;
            st_reg <= HS_WAIT;
          end
        end
        HS_RW: begin
          // Column command with auto precharge, write data alongside.
          if (cnt_reg == 16'h0000) begin
            cmd_reg <= wr_reg ? `SDRC_CMD_WR : `SDRC_CMD_RD;
            addr_reg <= {col_reg[11], 1'b1, col_reg[9:0]};
            dqh_oe_reg <= wr_reg;
            dqm_reg <= wr_reg ? dqm_reg : 2'h0;
            cnt_reg <= 16'(`SDRC_TRP_CYC + 2) + {13'h0000, CL};
            st_reg <= HS_WAIT;
          end else begin
            dqm_reg <= dqm_reg;
          end
        end
        HS_WAIT: begin
          if (cnt_reg == 16'h0000) begin
            o_ready <= 1'b1;
            st_reg <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// *** verilog/sdrc_defines.svh ***
// Purpose: Shared constants of the SDRAM command link, both ends.
// Assumes: One 200 MHz clock shared by controller and memory model.
// Notes: Times are given in their own unit; cycle counts derive from them.
`ifndef SDRC_DEFINES_SVH
`define SDRC_DEFINES_SVH

// Command codes as {select_n, row_n, column_n, write_n}.
`define SDRC_CMD_LMR 4'h0
`define SDRC_CMD_REF 4'h1
`define SDRC_CMD_PRE 4'h2
`define SDRC_CMD_ACT 4'h3
`define SDRC_CMD_WR 4'h4
`define SDRC_CMD_RD 4'h5
`define SDRC_CMD_BST 4'h6
`define SDRC_CMD_NOP 4'h7

// Address bit that asks for auto precharge or precharge of all banks.
`define SDRC_AP_BIT 10

// Mode word fields: burst length code [2:0], read latency [6:4].
`define SDRC_MR_BL_LSB 0
`define SDRC_MR_CL_LSB 4
`define SDRC_BL_FULL 3'h7
`define SDRC_MR_RESET 12'h020

// Array geometry.
`define SDRC_BANKS 4
`define SDRC_ROWS 4096
`define SDRC_COLS_X4 2048
`define SDRC_COLS_X8 1024
`define SDRC_COLS_X16 512

// Timing in nanoseconds, microseconds or milliseconds, then in clock cycles.
`define SDRC_CLK_NS 5
`define SDRC_TRCD_NS 20
`define SDRC_TRP_NS 20
`define SDRC_TRFC_NS 70
`define SDRC_TREF_MS 16
`define SDRC_INIT_US 100
`define SDRC_CYC_MIN(ns) (((ns) + `SDRC_CLK_NS - 1) / `SDRC_CLK_NS)
`define SDRC_TRCD_CYC `SDRC_CYC_MIN(`SDRC_TRCD_NS)
`define SDRC_TRP_CYC `SDRC_CYC_MIN(`SDRC_TRP_NS)
`define SDRC_TRFC_CYC `SDRC_CYC_MIN(`SDRC_TRFC_NS)
`define SDRC_TREFI_CYC ((`SDRC_TREF_MS * 1000000 / `SDRC_ROWS) / `SDRC_CLK_NS)
`define SDRC_INIT_CYC `SDRC_CYC_MIN(`SDRC_INIT_US * 1000)
`define SDRC_LMR_CYC 2

`endif

// *** verilog/sdrc_if.sv ***
// Purpose: Pin bundle between SDRAM controller and memory.
// Assumes: Both ends run on the same clock.
// Notes: The data wire is resolved here from the controller output enable alone.
`timescale 1ns/1ps
interface sdrc_if #(
  parameter int DW = 16
);
  logic cke;             // Clock gating, high lets the clock act.
  logic cs_n;            // Select, active low.
  logic ras_n;           // Row strobe, active low.
  logic cas_n;           // Column strobe, active low.
  logic we_n;            // Write strobe, active low.
  logic [1:0] ba;        // Bank select.
  logic [11:0] addr;     // Row, column or op code.
  logic [1:0] dqm;       // Data masks {data_mask_high_byte, data_mask_low_byte}.
  logic [DW-1:0] dq_h;   // Controller drive value.
  logic dq_h_oe;         // Controller drives the data wire.
  logic [DW-1:0] dq_d;   // Memory drive value.
  logic [1:0] dq_d_oe;   // Memory drives low and high byte lanes.
  logic [DW-1:0] dq;     // Resolved data wire.

  // The controller only drives during writes, so it takes priority.
  assign dq = dq_h_oe ? dq_h : dq_d;

  modport mem(input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
              output dq_d, dq_d_oe);
  modport ctrl(output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_h, dq_h_oe,
               input dq, dq_d_oe);
endinterface

// *** verilog/sdrc_mem.sv ***
// Purpose: Quad-bank synchronous DRAM end: decode, banks, bursts, power modes.
// Assumes: Inputs are valid around the rising edge of i_clk.
// Notes: The array is sized by ROWS; shrink it for fast simulation.
// Notes on behaviour
// R1 - All inputs sampled on rising clock edge.
// R2 - Four banks, 4096 rows, columns by width.
// R3 - Controller opens row before column command.
// R4 - Activate: bank inputs pick bank, address row.
// R5 - Column command: address gives start column.
// R6 - Burst 1, 2, 4, 8, full page; terminate.
// R7 - Auto precharge closes row at burst end.
// R8 - New column address accepted every cycle.
// R9 - Controller should hide precharge behind other banks; this controller runs one access at a time and waits out each precharge.
// R10 - Extended grade: refresh 16ms, no self refresh.
// R11 - Each edge advances burst counter and outputs.
// R12 - Clock gating low: power-down, suspend, self refresh.
// R13 - Gating watched level-wise during power-down modes.
// R14 - Inputs ignored during power-down and self refresh.
// R15 - Controller may hold clock gating high.
// R16 - Select high masks every command.
// R17 - Bursts and masks continue while deselected.
// R18 - Select and three strobes form command code.
// R19 - Mask blocks writes, tristates reads two later.
// R20 - Address bit ten selects auto precharge.
// R21 - Precharge: bit ten high closes all banks.
// R22 - Mode load takes op code from address.
// R23 - Controller sends no-operation when nothing wanted.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "sdrc_defines.svh"
module sdrc_mem
  import sdrc_pkg::*;
#(
  parameter int DW = 16,
  parameter int ROWS = `SDRC_ROWS,
  parameter bit EXT_TEMP = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  sdrc_if.mem bus
);
  // Column count follows the data width.
  localparam int COLS = (DW == 4) ? `SDRC_COLS_X4 :
                        (DW == 8) ? `SDRC_COLS_X8 : `SDRC_COLS_X16; // R2
  localparam int CW = $clog2(COLS);
  localparam int RW = $clog2(ROWS);
  localparam int DEPTH = `SDRC_BANKS * ROWS * COLS;

  logic [DW-1:0] mem [DEPTH];      // Storage of all four banks.
  sdrc_pm_t pm_reg, pm_next;       // Power and clock-gating state.
  logic [11:0] mode_reg;           // Loaded mode word.
  logic [3:0] open_reg;            // One bit per bank with a row open.
  logic [RW-1:0] row_reg [4];      // Open row of each bank.
  logic burst_reg;                 // A burst continues next cycle.
  logic bwr_reg;                   // The running burst writes.
  logic bap_reg;                   // The running burst ends in precharge.
  logic [1:0] bbank_reg;           // Bank of the running burst.
  logic [CW-1:0] bcol_reg;         // Next column of the running burst.
  logic [CW:0] bleft_reg;          // Beats still to go.
  logic [1:0] rdv_reg;             // Read pipeline valid stages.
  logic [DW-1:0] rdd_reg [2];      // Read pipeline data stages.
  logic [1:0] dqm_d_reg;           // Masks one cycle old.
  logic [DW-1:0] dq_o_reg;         // Read data on the pins.
  logic [1:0] dq_oe_reg;           // Read drive enables per lane.

  // Column field of the address pins for this width.
  function automatic logic [CW-1:0] col_of(input logic [11:0] a);
    logic [11:0] c;
    c = (DW == 4) ? {1'b0, a[11], a[9:0]} : {2'b00, a[9:0]};
    col_of = c[CW-1:0];
  endfunction

  // Next column: wraps inside the burst block, or the page when full.
  function automatic logic [CW-1:0] nxt_col(input logic [CW-1:0] col,
                                            input logic [CW:0] len);
    logic [CW-1:0] msk;
    msk = CW'(len - 1'b1);
    nxt_col = (col & ~msk) | (CW'(col + 1'b1) & msk);
  endfunction

  // Flat array index of one location.
  function automatic int idx(input logic [1:0] b, input logic [RW-1:0] r,
                             input logic [CW-1:0] c);
    idx = ((int'(b) * ROWS) + int'(r)) * COLS + int'(c);
  endfunction

  // Write merge that keeps bits of masked byte lanes.
  function automatic logic [DW-1:0] wr_merge(input logic [DW-1:0] old,
                                             input logic [DW-1:0] nw,
                                             input logic [1:0] msk);
    for (int i = 0; i < DW; i++) begin
      wr_merge[i] = msk[i / 8] ? old[i] : nw[i];
    end
  endfunction

  // Command decode; everything is taken at the rising edge only.
  wire clk_run = (pm_reg == PM_RUN) & bus.cke; // R1 R14
  wire [3:0] cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n}; // R18
  wire cmd_ok = clk_run & ~bus.cs_n; // R16
  wire is_lmr = cmd_ok & (cmd == `SDRC_CMD_LMR);
  wire is_act = cmd_ok & (cmd == `SDRC_CMD_ACT);
  wire is_pre = cmd_ok & (cmd == `SDRC_CMD_PRE);
  wire is_bst = cmd_ok & (cmd == `SDRC_CMD_BST);
  wire is_sref = ~bus.cs_n & (cmd == `SDRC_CMD_REF) & ~bus.cke & ~EXT_TEMP; // R10
  wire is_rw = cmd_ok & open_reg[bus.ba] &
               ((cmd == `SDRC_CMD_RD) | (cmd == `SDRC_CMD_WR)); // R3 R8

  // Burst length and read latency from the mode word.
  wire [2:0] bl_code = mode_reg[`SDRC_MR_BL_LSB +: 3];
  wire [2:0] cl = mode_reg[`SDRC_MR_CL_LSB +: 3];
  wire bl_full = (bl_code == `SDRC_BL_FULL);
  wire [CW:0] bl_len = bl_full ? (CW+1)'(COLS) : (CW+1)'(1 << bl_code[1:0]); // R6

  // The beat done at this edge: a new column command or the burst counter.
  wire beat = is_rw | (burst_reg & clk_run & ~is_bst); // R6 R11 R17
  wire bt_wr = is_rw ? (cmd == `SDRC_CMD_WR) : bwr_reg;
  wire [1:0] bt_bank = is_rw ? bus.ba : bbank_reg;
  wire [CW-1:0] bt_col = is_rw ? col_of(bus.addr) : bcol_reg; // R5
  wire bt_ap = is_rw ? bus.addr[`SDRC_AP_BIT] : bap_reg; // R20
  wire [CW:0] bt_left = is_rw ? bl_len : bleft_reg;
  wire bt_last = beat & ~bl_full & (bt_left == (CW+1)'(1));
  wire [1:0] dqm_eff = (DW == 16) ? bus.dqm : {2{bus.dqm[1]}};
  wire tap = (cl == 3'h3);
  int bt_idx;
  assign bt_idx = idx(bt_bank, row_reg[bt_bank], bt_col);

  assign bus.dq_d = dq_o_reg;
  assign bus.dq_d_oe = dq_oe_reg;

  // Clock gating low picks a mode from burst state, a self refresh command and bank state.
  always_comb begin
    pm_next = pm_reg;
    unique case (pm_reg)
      PM_RUN: begin
        if (!bus.cke) begin
          if (burst_reg) begin
            pm_next = PM_SUSP; // R12
          end else if (is_sref) begin
            pm_next = PM_SREF; // R12
          end else if (|open_reg) begin
            pm_next = PM_APD; // R12
          end else begin
            pm_next = PM_PPD; // R12
          end
        end
      end
      // Held modes end on the gating level alone, with no command needed.
      PM_SUSP, PM_APD, PM_PPD, PM_SREF: begin
        if (bus.cke) begin
          pm_next = PM_RUN; // R13
        end
      end
    endcase
  end

  // Power state register.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pm_reg <= PM_RUN;
    end else begin
      pm_reg <= pm_next;
    end
  end

  // Mode word load.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_reg <= `SDRC_MR_RESET;
    end else if (is_lmr) begin
      mode_reg <= bus.addr; // R22
    end
  end

  // Bank open and close, including precharge at burst end.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      open_reg <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        row_reg[b] <= '0;
      end
    end else begin
      if (bt_last & bt_ap) begin
        open_reg[bt_bank] <= 1'b0; // R7
      end
      if (is_act) begin
        open_reg[bus.ba] <= 1'b1; // R4
        row_reg[bus.ba] <= bus.addr[RW-1:0]; // R4
      end else if (is_pre && bus.addr[`SDRC_AP_BIT]) begin
        open_reg <= 4'h0; // R21
      end else if (is_pre) begin
        open_reg[bus.ba] <= 1'b0; // R21
      end
    end
  end

  // Burst address counter; it holds while the clock is gated off.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      burst_reg <= 1'b0;
      bwr_reg <= 1'b0;
      bap_reg <= 1'b0;
      bbank_reg <= 2'h0;
      bcol_reg <= '0;
      bleft_reg <= '0;
    end else if (beat) begin
      bwr_reg <= bt_wr;
      bap_reg <= bt_ap;
      bbank_reg <= bt_bank;
      bcol_reg <= nxt_col(bt_col, bl_len); // R11
      bleft_reg <= bl_full ? bt_left : bt_left - 1'b1;
      burst_reg <= ~bt_last;
    end else if (is_bst) begin
      burst_reg <= 1'b0; // R6
    end
  end

  // Array access; masked lanes of a write keep their old bits.
  always_ff @(posedge i_clk) begin
    if (beat & bt_wr) begin
      mem[bt_idx] <= wr_merge(mem[bt_idx], bus.dq, dqm_eff); // R19
    end
    if (clk_run) begin
      rdd_reg[0] <= mem[bt_idx];
      rdd_reg[1] <= rdd_reg[0];
    end
  end

  // Read pipeline and output registers; masks act two edges later.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdv_reg <= 2'h0;
      dqm_d_reg <= 2'h0;
      dq_o_reg <= '0;
      dq_oe_reg <= 2'h0;
    end else if (clk_run) begin
      rdv_reg <= {rdv_reg[0], beat & ~bt_wr};
      dqm_d_reg <= dqm_eff; // R17
      dq_o_reg <= rdd_reg[tap]; // R11
      dq_oe_reg <= {2{rdv_reg[tap]}} & ~dqm_d_reg; // R19
    end else if (pm_reg != PM_SUSP) begin
      dq_oe_reg <= 2'h0; // R14
    end
  end
endmodule

// *** verilog/sdrc_pkg.sv ***
// Purpose: State types of the SDRAM command link ends.
// Assumes: Constants come from sdrc_defines.svh.
// Notes: One-hot codes are written out.
package sdrc_pkg;

  // Power and clock-gating state of the memory end.
  typedef enum logic [4:0] {
    PM_RUN = 5'h01,
    PM_SUSP = 5'h02,
    PM_APD = 5'h04,
    PM_PPD = 5'h08,
    PM_SREF = 5'h10
  } sdrc_pm_t;

  // Sequencer state of the controller end.
  typedef enum logic [4:0] {
    HS_INIT = 5'h01,
    HS_LMR = 5'h02,
    HS_IDLE = 5'h04,
    HS_RW = 5'h08,
    HS_WAIT = 5'h10
  } sdrc_hs_t;

endpackage
